/* File: src/smmc_bank_match.sv */
`timescale 1ns/10ps
// Address and function-code decode of one memory bank
module smmc_bank_match (
   // Bank programming
   input wire logic [31:0] base_cfg,
   input wire logic [31:0] option_cfg,
   // Host cycle
   input wire smmc_pkg::smmc_host_s host,
   // Decode results
   output logic hit,
   output logic blocked
);
   import smmc_pkg::*;

   logic addr_ok;
   logic fc_ok;

   // Mask bits set mean the address bit takes part in the compare
   always_comb begin
      addr_ok = (((host.addr[ADDR_HI:ADDR_LO] ^ base_cfg[ADDR_HI:ADDR_LO])
                  & option_cfg[ADDR_HI:ADDR_LO]) == '0);
      // Processor space never matches, whatever the mask says
      fc_ok = ((((host.fc ^ base_cfg[BB_FC_LSB +: 4]) & option_cfg[BO_FCM_LSB +: 4]) == 4'h0)
               && (host.fc != FC_CPU_SPACE));
      hit = base_cfg[BB_VALID] && addr_ok && fc_ok;
      // A write into a protected bank is refused here
      blocked = hit && host.write && base_cfg[BB_WRITE_PROTECT];
   end
endmodule

/* File: src/smmc_pkg.sv */
// Notes on behaviour
// - Burst address outputs carry address bits three-two.
// - Double drive duplicates the bank-1 row strobe.
// - Wait 100 us, then eight initialisation reads.
// - One refresh per programmed count plus one prescaled periods.
// - Status records write-protect and parity errors.
// - Zero function-code mask excludes processor space.
// - Burst outputs follow bits, increment during bursts.
// - Parity error raises a level-5 interrupt request.
package smmc_pkg;
   // Register indexes on the register port
   localparam logic [4:0] IDX_GLOBAL = 5'h00;
   localparam logic [4:0] IDX_STATUS = 5'h01;
   localparam logic [4:0] IDX_MODULE = 5'h02;
   localparam logic [4:0] IDX_PROTECT = 5'h03;
   localparam logic [4:0] IDX_PORT_E = 5'h04;
   localparam logic [4:0] IDX_BASE0 = 5'h08;
   localparam logic [4:0] IDX_OPTION0 = 5'h10;
   localparam int NUM_BANKS = 8;
   // Reset values
   localparam logic [31:0] GLOBAL_RESET = 32'h0000_0000;
   localparam logic [31:0] MODULE_RESET = 32'h0000_000f;
   localparam logic [7:0] PROTECT_RESET = 8'hc0;
   localparam logic [15:0] PORT_E_RESET = 16'h0000;
   localparam logic [31:0] BANK_RESET = 32'h0000_0000;
   // Global memory config fields
   localparam int GM_REFRESH_ENABLE = 0;
   localparam int GM_PARITY_BUS_ERROR_ENABLE = 6;
   localparam int GM_COUNT_LSB = 8;
   localparam int GM_COUNT_W = 8;
   // Bank base config fields
   localparam int BB_VALID = 0;
   localparam int BB_WRITE_PROTECT = 1;
   localparam int BB_PARITY_ENABLE = 2;
   localparam int BB_BURST_ACK_ENABLE = 3;
   localparam int BB_FC_LSB = 4;
   // Bank option config fields
   localparam int BO_DRAM_SELECT = 0;
   localparam int BO_FCM_LSB = 4;
   // Shared address compare field, bits 27 down to 11
   localparam int ADDR_HI = 27;
   localparam int ADDR_LO = 11;
   // Memory status bits
   localparam int ST_WRITE_PROTECT = 0;
   localparam int ST_PARITY = 1;
   // Port E bit that routes the double-drive strobe out
   localparam int PE_DOUBLE_DRIVE = 6;
   // Function code of processor space (interrupt acknowledge)
   localparam logic [3:0] FC_CPU_SPACE = 4'h7;
   // Interrupt level raised on a parity error
   localparam logic [2:0] PARITY_IRQ_LEVEL = 3'h5;
   localparam logic [2:0] NO_IRQ_LEVEL = 3'h0;
   // DRAM start-up timing
   localparam int CLK_MHZ = 20;
   localparam int STARTUP_US = 100;
   localparam int STARTUP_CYCLES = STARTUP_US * CLK_MHZ;
   localparam logic [3:0] INIT_READS = 4'h8;
   localparam int REFRESH_PRESCALE = 16;

   // Host bus cycle as seen by the controller
   typedef struct packed {
      logic start;
      logic done;
      logic burst_beat;
      logic write;
      logic [3:0] fc;
      logic [31:0] addr;
   } smmc_host_s;

   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] idx;
      logic [31:0] wdata;
   } smmc_reg_s;
endpackage

/* File: src/smmc_top.sv */
`timescale 1ns/10ps
// Slave-mode memory controller: bank decode, burst address, refresh
module smmc_top #(
   parameter int NBANKS = smmc_pkg::NUM_BANKS
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Register port
   input wire smmc_pkg::smmc_reg_s reg_req,
   output logic [31:0] reg_rdata,
   // Host cycle
   input wire smmc_pkg::smmc_host_s host,
   // Parity error pin, active low
   input wire logic parity_error_pin_n,
   // Memory strobes, active low
   output logic [NBANKS-1:0] chip_select_n,
   output logic bank1_row_strobe_n,
   output logic bank1_double_drive_n,
   // Burst address outputs
   output logic [1:0] burst_address_outputs,
   // Refresh and start-up
   output logic refresh_req,
   output logic dram_ready,
   // Interrupt level request
   output logic [2:0] irq_level
);
   import smmc_pkg::*;

   // Decode width must cover all bank indexes; refused at elaboration
   if (NBANKS < 2 || NBANKS > 8) begin : g_bad_banks
      $error("NBANKS must lie between 2 and 8");
   end

   // Register file
   logic [31:0] global_memory_config_q, global_memory_config_d;
   logic [31:0] module_config_q, module_config_d;
   logic [7:0] system_protection_control_q, system_protection_control_d;
   logic [15:0] port_e_pin_assignment_q, port_e_pin_assignment_d;
   logic [1:0] memory_status_q, memory_status_d;
   logic [31:0] bank_base_config_q [NBANKS];
   logic [31:0] bank_base_config_d [NBANKS];
   logic [31:0] bank_option_config_q [NBANKS];
   logic [31:0] bank_option_config_d [NBANKS];
   logic [31:0] rdata_q, rdata_d;
   // Access state
   logic [NBANKS-1:0] sel_q, sel_d;
   logic [1:0] badd_q, badd_d;
   logic burst_ok_q, burst_ok_d;
   // Parity pin synchroniser, oldest stage at bit 2
   logic [2:0] parity_error_pin_sync_q, parity_error_pin_sync_d;
   // Refresh and start-up counters
   logic [4:0] pre_q, pre_d;
   logic [GM_COUNT_W-1:0] period_q, period_d;
   logic [11:0] start_q, start_d;
   logic [3:0] init_q, init_d;
   logic refresh_q, refresh_d;
   // Per-bank decode results
   logic [NBANKS-1:0] hit;
   logic [NBANKS-1:0] blocked;
   logic [NBANKS-1:0] parity_bank;
   logic [NBANKS-1:0] burst_bank;
   logic parity_seen;

   // Selects a bank register from its index and base index
   function automatic logic is_bank(input logic [4:0] idx, input logic [4:0] first,
                                    input int bank);
      return idx == first + 5'(bank);
   endfunction

   // One decoder per bank
   genvar g;
   generate
      for (g = 0; g < NBANKS; g++) begin : g_bank
         smmc_bank_match u_match (
            .base_cfg(bank_base_config_q[g]),
            .option_cfg(bank_option_config_q[g]),
            .host(host),
            .hit(hit[g]),
            .blocked(blocked[g])
         );
         assign parity_bank[g] = bank_base_config_q[g][BB_PARITY_ENABLE];
         assign burst_bank[g] = bank_base_config_q[g][BB_BURST_ACK_ENABLE];
      end
   endgenerate

   // Parity error counts only once two stable stages agree, on a parity bank
   assign parity_seen = !parity_error_pin_sync_q[1] && !parity_error_pin_sync_q[2] && ((sel_q & parity_bank) != '0);

   // Register writes, reads and status capture
   always_comb begin
      global_memory_config_d = global_memory_config_q;
      module_config_d = module_config_q;
      system_protection_control_d = system_protection_control_q;
      port_e_pin_assignment_d = port_e_pin_assignment_q;
      memory_status_d = memory_status_q;
      bank_base_config_d = bank_base_config_q;
      bank_option_config_d = bank_option_config_q;
      rdata_d = rdata_q;
      if (reg_req.wr) begin
         unique case (reg_req.idx)
            IDX_GLOBAL: global_memory_config_d = reg_req.wdata;
            IDX_MODULE: module_config_d = reg_req.wdata;
            IDX_PROTECT: system_protection_control_d = reg_req.wdata[7:0];
            IDX_PORT_E: port_e_pin_assignment_d = reg_req.wdata[15:0];
            // Status clears by writing ones
            IDX_STATUS: memory_status_d = memory_status_q & ~reg_req.wdata[1:0];
            default: begin
               // Bank registers; other indexes are ignored
               for (int b = 0; b < NBANKS; b++) begin
                  if (is_bank(reg_req.idx, IDX_BASE0, b)) begin
                     bank_base_config_d[b] = reg_req.wdata;
                  end
                  if (is_bank(reg_req.idx, IDX_OPTION0, b)) begin
                     bank_option_config_d[b] = reg_req.wdata;
                  end
               end
            end
         endcase
      end
      // Hardware sets after the clear so a same-cycle event survives
      if (host.start && (blocked != '0)) begin
         memory_status_d[ST_WRITE_PROTECT] = 1'b1;
      end
      if (parity_seen) begin
         memory_status_d[ST_PARITY] = 1'b1;
      end
      if (reg_req.rd) begin
         unique case (reg_req.idx)
            IDX_GLOBAL: rdata_d = global_memory_config_q;
            IDX_MODULE: rdata_d = module_config_q;
            IDX_PROTECT: rdata_d = {24'h0, system_protection_control_q};
            IDX_PORT_E: rdata_d = {16'h0, port_e_pin_assignment_q};
            IDX_STATUS: rdata_d = {30'h0, memory_status_q};
            default: begin
               // Unmapped indexes read as zero
               rdata_d = 32'h0;
               for (int b = 0; b < NBANKS; b++) begin
                  if (is_bank(reg_req.idx, IDX_BASE0, b)) begin
                     rdata_d = bank_base_config_q[b];
                  end
                  if (is_bank(reg_req.idx, IDX_OPTION0, b)) begin
                     rdata_d = bank_option_config_q[b];
                  end
               end
            end
         endcase
      end
   end

   // Access tracking and burst address generation
   always_comb begin
      sel_d = sel_q;
      badd_d = badd_q;
      burst_ok_d = burst_ok_q;
      parity_error_pin_sync_d = {parity_error_pin_sync_q[1:0], parity_error_pin_n};
      if (host.start) begin
         // Refused writes assert no strobe at all
         sel_d = (blocked != '0) ? '0 : hit;
         badd_d = host.addr[3:2];
         burst_ok_d = ((hit & burst_bank) != '0);
      end else if (host.done) begin
         sel_d = '0;
      end else if (host.burst_beat && burst_ok_q && (sel_q != '0)) begin
         // Wraps within the line as the host burst expects
         badd_d = badd_q + 2'h1;
      end
   end

   // Refresh timer and DRAM start-up sequence
   always_comb begin
      pre_d = pre_q;
      period_d = period_q;
      start_d = start_q;
      init_d = init_q;
      refresh_d = 1'b0;
      // Start-up wait runs from reset regardless of programming
      if (start_q != 12'(STARTUP_CYCLES)) begin
         start_d = start_q + 12'h1;
      end else if (global_memory_config_q[GM_REFRESH_ENABLE]) begin
         if (init_q != INIT_READS) begin
            // Eight back-to-back initialisation cycles
            refresh_d = 1'b1;
            init_d = init_q + 4'h1;
         end else if (pre_q != 5'(REFRESH_PRESCALE - 1)) begin
            pre_d = pre_q + 5'h1;
         end else begin
            pre_d = 5'h0;
            // One refresh per programmed count plus one prescaled ticks
            if (period_q >= global_memory_config_q[GM_COUNT_LSB +: GM_COUNT_W]) begin
               period_d = '0;
               refresh_d = 1'b1;
            end else begin
               period_d = period_q + 1'b1;
            end
         end
      end
   end

   // State registers; the enable freezes everything
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         global_memory_config_q <= GLOBAL_RESET;
         module_config_q <= MODULE_RESET;
         system_protection_control_q <= PROTECT_RESET;
         port_e_pin_assignment_q <= PORT_E_RESET;
         memory_status_q <= 2'h0;
         for (int b = 0; b < NBANKS; b++) begin
            bank_base_config_q[b] <= BANK_RESET;
            bank_option_config_q[b] <= BANK_RESET;
         end
         rdata_q <= 32'h0;
         sel_q <= '0;
         badd_q <= 2'h0;
         burst_ok_q <= 1'b0;
         parity_error_pin_sync_q <= 3'h7;
         pre_q <= 5'h0;
         period_q <= '0;
         start_q <= 12'h0;
         init_q <= 4'h0;
         refresh_q <= 1'b0;
      end else if (clk_en) begin
         global_memory_config_q <= global_memory_config_d;
         module_config_q <= module_config_d;
         system_protection_control_q <= system_protection_control_d;
         port_e_pin_assignment_q <= port_e_pin_assignment_d;
         memory_status_q <= memory_status_d;
         bank_base_config_q <= bank_base_config_d;
         bank_option_config_q <= bank_option_config_d;
         rdata_q <= rdata_d;
         sel_q <= sel_d;
         badd_q <= badd_d;
         burst_ok_q <= burst_ok_d;
         parity_error_pin_sync_q <= parity_error_pin_sync_d;
         pre_q <= pre_d;
         period_q <= period_d;
         start_q <= start_d;
         init_q <= init_d;
         refresh_q <= refresh_d;
      end
   end

   // Outputs
   assign reg_rdata = rdata_q;
   assign chip_select_n = ~sel_q;
   assign bank1_row_strobe_n = ~(sel_q[1] && bank_option_config_q[1][BO_DRAM_SELECT]);
   // Second driver of the same strobe for heavy module loads
   assign bank1_double_drive_n = port_e_pin_assignment_q[PE_DOUBLE_DRIVE]
                                 ? bank1_row_strobe_n : 1'b1;
   assign burst_address_outputs = badd_q;
   assign refresh_req = refresh_q;
   assign dram_ready = (init_q == INIT_READS);
   // Level held until software clears the parity status bit
   assign irq_level = memory_status_q[ST_PARITY] ? PARITY_IRQ_LEVEL : NO_IRQ_LEVEL;
endmodule

/* File: testbench/smmc_assertions.sv */
`timescale 1ns/10ps
// Port-level checks of the slave-mode memory controller
module smmc_assertions #(
   parameter int NBANKS = 8
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Requests
   input wire smmc_pkg::smmc_reg_s reg_req,
   input wire logic [31:0] reg_rdata,
   input wire smmc_pkg::smmc_host_s host,
   input wire logic parity_error_pin_n,
   // Strobes, burst, refresh, interrupt
   input wire logic [NBANKS-1:0] chip_select_n,
   input wire logic bank1_row_strobe_n,
   input wire logic bank1_double_drive_n,
   input wire logic [1:0] burst_address_outputs,
   input wire logic refresh_req,
   input wire logic dram_ready,
   input wire logic [2:0] irq_level
);
   import smmc_pkg::*;
   // One clock domain, so one default clock and reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   a_cpu_space_miss: assert property (
      host.start && clk_en && host.fc == FC_CPU_SPACE |=> &chip_select_n)
      else $error("Processor space cycle selected a bank");
   a_burst_load: assert property (
      host.start && clk_en |=> burst_address_outputs == $past(host.addr[3:2]))
      else $error("Burst address not loaded from the cycle address");
   a_burst_hold: assert property (
      !host.start && !host.burst_beat |=> $stable(burst_address_outputs))
      else $error("Burst address moved without a beat");
   a_dd_copy: assert property (
      !bank1_double_drive_n |-> !bank1_row_strobe_n)
      else $error("Double drive strobe without the row strobe");
   a_row_cs: assert property (
      !bank1_row_strobe_n |-> !chip_select_n[1])
      else $error("Row strobe without bank 1 selected");
   a_irq_level: assert property (
      irq_level != NO_IRQ_LEVEL |-> irq_level == PARITY_IRQ_LEVEL)
      else $error("Interrupt request at a wrong level");
   a_irq_cause: assert property (
      $rose(irq_level != NO_IRQ_LEVEL) |->
         !$past(parity_error_pin_n, 3) && !$past(parity_error_pin_n, 4))
      else $error("Interrupt request without a synchronised parity error");
   a_refresh_gap: assert property (
      refresh_req && dram_ready && $past(dram_ready) |=> !refresh_req [*8])
      else $error("Refresh pulses too close after start-up");
   a_ready_stays: assert property (
      dram_ready |=> dram_ready)
      else $error("DRAM ready dropped");
   a_ready_after: assert property (
      $rose(dram_ready) |-> refresh_req || $past(refresh_req))
      else $error("DRAM ready without an initialisation refresh");
   // Main scenarios reached
   c_refresh: cover property (refresh_req && dram_ready);
   c_parity: cover property (irq_level == PARITY_IRQ_LEVEL);
   c_burst: cover property (host.burst_beat && !chip_select_n[1]);
endmodule

bind smmc_top smmc_assertions #(.NBANKS(NBANKS)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata), .host(host),
   .parity_error_pin_n(parity_error_pin_n), .chip_select_n(chip_select_n),
   .bank1_row_strobe_n(bank1_row_strobe_n), .bank1_double_drive_n(bank1_double_drive_n),
   .burst_address_outputs(burst_address_outputs), .refresh_req(refresh_req),
   .dram_ready(dram_ready), .irq_level(irq_level));

/* File: testbench/smmc_host_model.sv */
`timescale 1ns/10ps
// External host: runs memory cycles and the parity error pin
module smmc_host_model (
   // Clock
   input wire logic sys_clk,
   // Host bus and parity pin
   output smmc_pkg::smmc_host_s host,
   output logic parity_error_pin_n
);
   import smmc_pkg::*;
   // Idle bus at time zero
   initial begin
      host = '0;
      parity_error_pin_n = 1'b1;
   end
   // One cycle: start, wait states, burst beats, done, then release
   task automatic cycle(input logic [31:0] a, input logic [3:0] f, input logic w,
                        input int nb, input logic parity_error_pin);
      @(posedge sys_clk);
      host <= '{1'b1, 1'b0, 1'b0, w, f, a};
      @(posedge sys_clk);
      host.start <= 1'b0;
      // Pin held low long enough for the synchroniser
      parity_error_pin_n <= !parity_error_pin;
      repeat (8) @(posedge sys_clk);
      for (int k = 0; k < nb; k++) begin
         host.burst_beat <= 1'b1;
         @(posedge sys_clk);
      end
      host.burst_beat <= 1'b0;
      host.done <= 1'b1;
      parity_error_pin_n <= 1'b1;
      @(posedge sys_clk);
      // Released lines show the inverse, never the old address
      host <= '{1'b0, 1'b0, 1'b0, ~w, ~f, ~a};
   endtask
endmodule

/* File: testbench/smmc_top_tb_top.sv */
`timescale 1ns/10ps
// Self-checking bench of the slave-mode memory controller
module smmc_top_tb_top;
   import smmc_pkg::*;
   // Compare one value and count it
   `define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); end end
   logic sys_clk = 1'b0;
   logic rst_n, clk_en, parity_error_pin_n;
   smmc_reg_s reg_req;
   smmc_host_s host;
   logic [31:0] reg_rdata, a1, d, e_v;
   logic [7:0] chip_select_n;
   logic bank1_row_strobe_n, bank1_double_drive_n, refresh_req, dram_ready;
   logic [1:0] burst_address_outputs;
   logic [2:0] irq_level;
   // Expected results in issue order
   logic [31:0] exp_q[$];
   int n_mismatch = 0;
   int samples_checked = 0;
   int seed, gap;
   logic st_q, rd_q, bt_q;
   always #25 sys_clk = ~sys_clk;
   smmc_top #(.NBANKS(8)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .host(host),
      .parity_error_pin_n(parity_error_pin_n), .chip_select_n(chip_select_n),
      .bank1_row_strobe_n(bank1_row_strobe_n), .bank1_double_drive_n(bank1_double_drive_n),
      .burst_address_outputs(burst_address_outputs), .refresh_req(refresh_req),
      .dram_ready(dram_ready), .irq_level(irq_level));
   smmc_host_model u_host (.sys_clk(sys_clk), .host(host),
      .parity_error_pin_n(parity_error_pin_n));
   // Note what the controller took at this edge
   always @(posedge sys_clk) begin
      st_q <= host.start;
      rd_q <= reg_req.rd;
      bt_q <= host.burst_beat;
   end
   // Outputs settle by the falling edge; match them to the oldest note
   always @(negedge sys_clk) begin
      if (rd_q === 1'b1 || st_q === 1'b1 || bt_q === 1'b1) begin
         e_v = exp_q.pop_front();
      end
      if (rd_q === 1'b1) `CHK("reg_rdata", e_v, reg_rdata)
      if (st_q === 1'b1) `CHK("chip_select_n", e_v[7:0], chip_select_n)
      if (st_q === 1'b1) `CHK("bank1_row_strobe_n", e_v[1], bank1_row_strobe_n)
      if (st_q === 1'b1) `CHK("bank1_double_drive_n", e_v[1], bank1_double_drive_n)
      if (bt_q === 1'b1) `CHK("burst", e_v[1:0], burst_address_outputs)
   end
   // Register read with its expected word
   task automatic rd(input logic [4:0] i, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge sys_clk);
      reg_req <= '{1'b0, 1'b1, i, 32'h0};
      @(posedge sys_clk);
      reg_req.rd <= 1'b0;
   endtask
   // Register write, one strobe cycle
   task automatic wr(input logic [4:0] i, input logic [31:0] v);
      @(posedge sys_clk);
      reg_req <= '{1'b1, 1'b0, i, v};
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask
   // Host cycle: expected strobes, then one burst address per beat
   task automatic hc(input logic [31:0] a, input logic [3:0] f, input logic w,
                     input int nb, input logic parity_error_pin, input logic [7:0] cs);
      logic [1:0] b;
      b = a[3:2];
      exp_q.push_back({24'h0, cs});
      for (int k = 0; k < nb; k++) begin
         b = b + 2'h1;
         exp_q.push_back({30'h0, b});
      end
      u_host.cycle(a, f, w, nb, parity_error_pin);
   endtask
   // Verdict and end of run
   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Hang guard, well beyond start-up plus traffic
   initial begin
      #(8000 * 50);
      n_mismatch++;
      stop_test;
   end
   initial begin
      seed = 32'h6d15010c;
      rst_n = 1'b0;
      clk_en = 1'b1;
      reg_req = '0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      // Reset values, unmapped index reads zero
      rd(IDX_GLOBAL, GLOBAL_RESET);
      rd(IDX_MODULE, MODULE_RESET);
      rd(IDX_PROTECT, {24'h0, PROTECT_RESET});
      rd(IDX_PORT_E, {16'h0, PORT_E_RESET});
      rd(IDX_STATUS, 32'h0);
      rd(IDX_BASE0, BANK_RESET);
      rd(IDX_OPTION0, BANK_RESET);
      rd(5'h05, 32'h0);
      d = $random(seed);
      wr(IDX_MODULE, d);
      wr(IDX_PROTECT, {24'h0, PROTECT_RESET});
      rd(IDX_MODULE, d);
      // DRAM bank 1 (1 Mbyte, parity, burst) and write-protected EEPROM bank 4
      wr(IDX_BASE0 + 5'h01, 32'h0010_000d);
      wr(IDX_OPTION0 + 5'h01, 32'h0ff0_0001);
      wr(IDX_BASE0 + 5'h04, 32'h0020_0003);
      wr(IDX_OPTION0 + 5'h04, 32'h0fff_8000);
      wr(IDX_PORT_E, 32'h0000_31c0);
      rd(IDX_PORT_E, 32'h0000_31c0);
      // Frozen enable: a write while clk_en is low must not land
      clk_en <= 1'b0;
      wr(IDX_PORT_E, 32'h0000_0000);
      clk_en <= 1'b1;
      rd(IDX_PORT_E, 32'h0000_31c0);
      // Burst that wraps the two address bits
      a1 = 32'h0010_0008 | ($random(seed) & 32'h000f_fff0);
      hc(a1, 4'h5, 1'b0, 3, 1'b0, 8'hfd);
      // Function codes 0 to 7; processor space never selects
      for (int f = 0; f < 8; f++) hc(a1, f[3:0], 1'b0, 0, 1'b0, (f == 7) ? 8'hff : 8'hfd);
      // EEPROM byte lane steps by four; write is refused and recorded
      hc(32'h0020_0000, 4'h5, 1'b0, 0, 1'b0, 8'hef);
      hc(32'h0020_0004, 4'h5, 1'b0, 0, 1'b0, 8'hef);
      hc(32'h0020_0008, 4'h5, 1'b1, 0, 1'b0, 8'hff);
      // Polling read of the same byte after the write attempt
      hc(32'h0020_0008, 4'h5, 1'b0, 0, 1'b0, 8'hef);
      rd(IDX_STATUS, 32'h1);
      wr(IDX_STATUS, 32'h1);
      rd(IDX_STATUS, 32'h0);
      // Parity fault on the parity bank
      hc(a1, 4'h1, 1'b0, 0, 1'b1, 8'hfd);
      rd(IDX_STATUS, 32'h2);
      @(negedge sys_clk);
      `CHK("irq_level", PARITY_IRQ_LEVEL, irq_level)
      wr(IDX_STATUS, 32'h2);
      rd(IDX_STATUS, 32'h0);
      @(negedge sys_clk);
      `CHK("irq_level", NO_IRQ_LEVEL, irq_level)
      // Refresh: count 1 gives a period of two prescale spans
      wr(IDX_GLOBAL, 32'h0000_0101);
      rd(IDX_GLOBAL, 32'h0000_0101);
      for (int k = 0; k < 4000 && dram_ready !== 1'b1; k++) @(negedge sys_clk);
      `CHK("dram_ready", 1'b1, dram_ready)
      for (int k = 0; k < 100 && refresh_req !== 1'b1; k++) @(negedge sys_clk);
      @(negedge sys_clk);
      for (gap = 1; gap < 100 && refresh_req !== 1'b1; gap++) @(negedge sys_clk);
      `CHK("refresh_gap", 2 * REFRESH_PRESCALE, gap)
      stop_test;
   end
endmodule
